// File: hdl/mfio_ports.sv
`timescale 1ns/1ps
// Operation
// (R1) Pin levels are sampled in the read state.
// (R2) Written output value updates in write state.
// (R3) Outputs latched; inputs unlatched, source holds data.
// (R4) Port 0: eight pins, per-bit direction.
// (R5) Reset clears port 0 latch, direction, LCD.
// (R6) Port 0 read: pin, zero, or latch.
// (R7) Port 0 LCD select routes segment to pin.
// (R8) Serial output needs direction, latch one, no LCD.
// (R9) Inputs need direction and LCD cleared.
// (R10) Port 1: eight pins, per-bit direction.
// (R11) Reset clears port 1 latch, direction, LCD.
// (R12) Port 1 read: pin, zero, or latch.
// (R13) Port 1 LCD select routes segment to pin.
// (R14) Port 2 three bits, latch resets to ones.
// (R15) Software sets port 2 latch before input use.
// (R16) Dual-clock mode gives bits 1, 2 to oscillator.
// (R17) Falling edge on port 2 bit 0 flags interrupt.
// (R18) Port 2 latch and pins read separately.
// (R19) Port 2 upper read bits are meaningless.
// (R20) Stop mode floats port 2 bit 0.
// (R21) Read-modify-write takes pin level for input bits.
// (R22) Reassign pins before configuring, never while running.
// (R23) LCD-selected pins ignore direction and latch.
// (R24) Secondary inputs always see live pin levels.
module mfio_ports (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic [11:0] i_cpu_addr,
  input wire logic [7:0] i_cpu_wdata,
  input wire logic i_cpu_read_sample_state,
  input wire logic i_cpu_write_update_state,
  output logic [7:0] o_cpu_rdata,
  input wire logic [7:0] i_p0_pin,
  input wire logic [7:0] i_p1_pin,
  input wire logic [2:0] i_p2_pin,
  input wire logic [7:0] i_p0_lcd_seg,
  input wire logic [7:0] i_p1_lcd_seg,
  input wire logic [7:0] i_p0_periph_out,
  input wire logic i_dual_clock_mode,
  input wire logic i_stop_mode,
  output mfio_pkg::mfio_drv8_t o_p0_drive,
  output mfio_pkg::mfio_drv8_t o_p1_drive,
  output mfio_pkg::mfio_drv3_t o_p2_drive,
  output logic [7:0] o_p0_func_in,
  output logic [2:0] o_p2_func_in,
  output logic o_p2_bit0_fall,
  output logic [7:0] o_pin_reassign_select
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] port0_output_latch; // Port 0 output data latch.
  logic [7:0] port0_direction; // Port 0 direction, 1 is output.
  logic [7:0] port0_lcd_select; // Port 0 LCD segment select.
  logic [7:0] port1_output_latch; // Port 1 output data latch.
  logic [7:0] port1_direction; // Port 1 direction, 1 is output.
  logic [7:0] port1_lcd_select; // Port 1 LCD segment select.
  logic [2:0] port2_output_latch; // Port 2 output latch.
  logic p2_bit0_prev; // Last level of port 2 bit 0.

  // ----------------------------------------------------------------
  // Address decode and read selection
  // ----------------------------------------------------------------
  wire logic hit_p0_latch = (i_cpu_addr == mfio_pkg::ADDR_P0_LATCH);
  wire logic hit_p1_latch = (i_cpu_addr == mfio_pkg::ADDR_P1_LATCH);
  wire logic hit_p2_latch = (i_cpu_addr == mfio_pkg::ADDR_P2_LATCH);
  wire logic hit_p0_dir = (i_cpu_addr == mfio_pkg::ADDR_P0_DIR);
  wire logic hit_p1_dir = (i_cpu_addr == mfio_pkg::ADDR_P1_DIR);
  wire logic hit_p2_pin = (i_cpu_addr == mfio_pkg::ADDR_P2_PIN);
  wire logic hit_p0_lcd = (i_cpu_addr == mfio_pkg::ADDR_P0_LCD);
  wire logic hit_p1_lcd = (i_cpu_addr == mfio_pkg::ADDR_P1_LCD);
  wire logic hit_reassign = (i_cpu_addr == mfio_pkg::ADDR_REASSIGN);
  wire logic wr = i_cpu_write_update_state;

  // Per-bit read view of the data registers: latch for outputs, pin for
  // plain inputs, zero for LCD inputs. A bit instruction that reads this
  // and writes it back copies pin levels into input-mode latches.
  wire logic [7:0] p0_view = (port0_direction & port0_output_latch) // R6 R21
    | (~port0_direction & ~port0_lcd_select & i_p0_pin); // R6
  wire logic [7:0] p1_view = (port1_direction & port1_output_latch) // R12 R21
    | (~port1_direction & ~port1_lcd_select & i_p1_pin); // R12

  // Port 2 upper bits read as zero; only the low three carry meaning.
  wire logic [7:0] p2_latch_view = {5'h00, port2_output_latch}; // R18 R19
  wire logic [7:0] p2_pin_view = {5'h00, i_p2_pin}; // R18 R19

  wire logic [7:0] read_mux =
    hit_p0_latch ? p0_view :
    hit_p1_latch ? p1_view :
    hit_p2_latch ? p2_latch_view :
    hit_p0_dir ? port0_direction :
    hit_p1_dir ? port1_direction :
    hit_p2_pin ? p2_pin_view :
    hit_p0_lcd ? port0_lcd_select :
    hit_p1_lcd ? port1_lcd_select :
    hit_reassign ? o_pin_reassign_select : 8'h00;

  // ----------------------------------------------------------------
  // Pin drive computation
  // ----------------------------------------------------------------
  // An LCD pin always carries the segment, whatever direction and latch
  // say. A serial output only appears while the latch bit is one.
  wire logic [7:0] next_p0_out = (port0_lcd_select & i_p0_lcd_seg) // R7 R23
    | (~port0_lcd_select & port0_output_latch & i_p0_periph_out); // R8
  wire logic [7:0] next_p0_oe = port0_lcd_select | port0_direction; // R4 R7 R23
  wire logic [7:0] next_p1_out = (port1_lcd_select & i_p1_lcd_seg) // R13 R23
    | (~port1_lcd_select & port1_output_latch);
  wire logic [7:0] next_p1_oe = port1_lcd_select | port1_direction; // R10 R13 R23

  // Port 2 sinks low when its latch is zero and floats when one, so a one
  // in the latch leaves the pin free for input and secondary use.
  wire logic [2:0] p2_sink = ~port2_output_latch; // R15
  wire logic [2:0] next_p2_oe = {
    p2_sink[mfio_pkg::P2_BIT_XOUT] & ~i_dual_clock_mode, // R16
    p2_sink[mfio_pkg::P2_BIT_XIN] & ~i_dual_clock_mode, // R16
    p2_sink[mfio_pkg::P2_BIT_INT] & ~i_stop_mode // R20
  };
  // The level seen on bit 0 follows our own drive when we sink it.
  wire logic p2_bit0_level = next_p2_oe[mfio_pkg::P2_BIT_INT] ? 1'b0
    : i_p2_pin[mfio_pkg::P2_BIT_INT];

  // ----------------------------------------------------------------
  // Read data capture
  // ----------------------------------------------------------------
  // Pins enter the read data only in the read state; the secondary inputs register them every clock.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_cpu_rdata <= 8'h00;
    end else if (i_cpu_read_sample_state) begin
      o_cpu_rdata <= read_mux; // R1 R3
    end
  end

  // ----------------------------------------------------------------
  // Port 0 registers
  // ----------------------------------------------------------------
  // Writes take effect in the write state of the instruction.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      port0_output_latch <= mfio_pkg::RST_ZERO; // R5
      port0_direction <= mfio_pkg::RST_ZERO; // R5
      port0_lcd_select <= mfio_pkg::RST_ZERO; // R5
    end else begin
      if (wr && hit_p0_latch) begin
        port0_output_latch <= i_cpu_wdata; // R2 R3
      end
      if (wr && hit_p0_dir) begin
        port0_direction <= i_cpu_wdata; // R4
      end
      if (wr && hit_p0_lcd) begin
        port0_lcd_select <= i_cpu_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Port 1 registers
  // ----------------------------------------------------------------
  // Same structure as port 0, without serial functions.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      port1_output_latch <= mfio_pkg::RST_ZERO; // R11
      port1_direction <= mfio_pkg::RST_ZERO; // R11
      port1_lcd_select <= mfio_pkg::RST_ZERO; // R11
    end else begin
      if (wr && hit_p1_latch) begin
        port1_output_latch <= i_cpu_wdata; // R2 R3
      end
      if (wr && hit_p1_dir) begin
        port1_direction <= i_cpu_wdata; // R10
      end
      if (wr && hit_p1_lcd) begin
        port1_lcd_select <= i_cpu_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Port 2 latch and reassignment register
  // ----------------------------------------------------------------
  // The reassignment value is only stored; software must set it before
  // touching the affected pins, the block does not guard against that.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      port2_output_latch <= mfio_pkg::RST_P2_LATCH; // R14
      o_pin_reassign_select <= mfio_pkg::RST_ZERO;
    end else begin
      if (wr && hit_p2_latch) begin
        port2_output_latch <= i_cpu_wdata[mfio_pkg::P2_WIDTH-1:0]; // R2 R14
      end
      if (wr && hit_reassign) begin
        o_pin_reassign_select <= i_cpu_wdata; // R22
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered pin drives and secondary inputs
  // ----------------------------------------------------------------
  // Outputs are registered so each pin changes one clock after its cause.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_p0_drive <= '0;
      o_p1_drive <= '0;
      o_p2_drive <= '0;
      o_p0_func_in <= 8'h00;
      o_p2_func_in <= 3'h0;
    end else begin
      o_p0_drive <= {next_p0_out, next_p0_oe};
      o_p1_drive <= {next_p1_out, next_p1_oe};
      o_p2_drive <= {3'h0, next_p2_oe};
      o_p0_func_in <= i_p0_pin; // R24
      o_p2_func_in <= i_p2_pin; // R24
    end
  end

  // ----------------------------------------------------------------
  // Port 2 bit 0 falling edge
  // ----------------------------------------------------------------
  // The edge is taken from the pin level, which also covers our own
  // output driving the pin low.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      p2_bit0_prev <= 1'b1;
      o_p2_bit0_fall <= 1'b0;
    end else begin
      p2_bit0_prev <= p2_bit0_level;
      o_p2_bit0_fall <= p2_bit0_prev & ~p2_bit0_level; // R17
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  sequence s_p0_write;
    wr && hit_p0_latch;
  endsequence

  property p_p0_write_update;
    s_p0_write ##1 1'b1 |-> port0_output_latch == $past(i_cpu_wdata);
  endproperty
  a_p0_write_update: assert property (p_p0_write_update) else $error("p0 latch write lost"); // R2

  property p_read_sample;
    i_cpu_read_sample_state |=> o_cpu_rdata == $past(read_mux);
  endproperty
  a_read_sample: assert property (p_read_sample) else $error("read data not sampled"); // R1

  property p_p0_lcd_read_zero;
    (i_cpu_read_sample_state && hit_p0_latch && port0_lcd_select[2] && !port0_direction[2])
      |=> !o_cpu_rdata[2];
  endproperty
  a_p0_lcd_read_zero: assert property (p_p0_lcd_read_zero) else $error("lcd bit reads nonzero"); // R6

  property p_p1_out_read_latch;
    (i_cpu_read_sample_state && hit_p1_latch)
      |=> o_cpu_rdata == $past((port1_direction & port1_output_latch)
        | (~port1_direction & ~port1_lcd_select & i_p1_pin));
  endproperty
  a_p1_out_read_latch: assert property (p_p1_out_read_latch) else $error("p1 read wrong"); // R12

  property p_p0_lcd_drive;
    port0_lcd_select[3] |=> o_p0_drive.oe[3] && o_p0_drive.out[3] == $past(i_p0_lcd_seg[3]);
  endproperty
  a_p0_lcd_drive: assert property (p_p0_lcd_drive) else $error("lcd segment not routed"); // R7

  property p_p1_lcd_drive;
    port1_lcd_select[5] |=> o_p1_drive.oe[5] && o_p1_drive.out[5] == $past(i_p1_lcd_seg[5]);
  endproperty
  a_p1_lcd_drive: assert property (p_p1_lcd_drive) else $error("p1 lcd not routed"); // R13

  property p_stop_float;
    i_stop_mode |=> !o_p2_drive.oe[0];
  endproperty
  a_stop_float: assert property (p_stop_float) else $error("p2 bit0 driven in stop"); // R20

  property p_dual_clock;
    i_dual_clock_mode |=> o_p2_drive.oe[2:1] == 2'h0;
  endproperty
  a_dual_clock: assert property (p_dual_clock) else $error("osc pins driven"); // R16

  property p_p2_fall;
    ($fell(p2_bit0_level)) |=> o_p2_bit0_fall ##1 !o_p2_bit0_fall;
  endproperty
  a_p2_fall: assert property (p_p2_fall) else $error("p2 fall not flagged once"); // R17

  property p_p2_upper_zero;
    (i_cpu_read_sample_state && (hit_p2_pin || hit_p2_latch)) |=> o_cpu_rdata[7:3] == 5'h00;
  endproperty
  a_p2_upper_zero: assert property (p_p2_upper_zero) else $error("p2 upper bits set"); // R19

endmodule

// File: hdl/mfio_pkg.sv
package mfio_pkg;

  // ----------------------------------------------------------------
  // Register addresses on the CPU data space
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_P0_LATCH = 12'h000; // Port 0 output latch.
  localparam logic [11:0] ADDR_P1_LATCH = 12'h001; // Port 1 output latch.
  localparam logic [11:0] ADDR_P2_LATCH = 12'h002; // Port 2 output latch.
  localparam logic [11:0] ADDR_P0_DIR = 12'h010; // Port 0 direction.
  localparam logic [11:0] ADDR_P1_DIR = 12'h011; // Port 1 direction.
  localparam logic [11:0] ADDR_P2_PIN = 12'h016; // Port 2 pin levels, read only.
  localparam logic [11:0] ADDR_P0_LCD = 12'hFAC; // Port 0 LCD select.
  localparam logic [11:0] ADDR_P1_LCD = 12'hFAD; // Port 1 LCD select.
  localparam logic [11:0] ADDR_REASSIGN = 12'hFBB; // Pin reassignment select.

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int P2_WIDTH = 3; // Port 2 has three implemented bits.
  localparam logic [7:0] RST_ZERO = 8'h00; // Reset of ports 0 and 1 registers.
  localparam logic [2:0] RST_P2_LATCH = 3'h7; // Port 2 latch resets to ones.
  localparam int P2_BIT_INT = 0; // Port 2 bit shared with the stop/interrupt input.
  localparam int P2_BIT_XIN = 1; // Port 2 bit for the slow oscillator input.
  localparam int P2_BIT_XOUT = 2; // Port 2 bit for the slow oscillator output.

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  // Drive of an eight-bit port: level and output enable per pin.
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } mfio_drv8_t;

  // Drive of the three-bit port.
  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } mfio_drv3_t;

endpackage

// File: verification/mfio_pin_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Pad model: what the outside world sees on each port pin.
// ------------------------------------------------------------
module mfio_pin_model (
  input wire mfio_pkg::mfio_drv8_t i_p0_drive,
  input wire mfio_pkg::mfio_drv8_t i_p1_drive,
  input wire mfio_pkg::mfio_drv3_t i_p2_drive,
  input wire logic [7:0] i_p0_ext,
  input wire logic [7:0] i_p1_ext,
  input wire logic [2:0] i_p2_ext,
  output logic [7:0] o_p0_pin,
  output logic [7:0] o_p1_pin,
  output logic [2:0] o_p2_pin
);
  // A driven pad shows the port level; a released pad shows the outside source.
  // The outside source keeps its level until the bench changes it on purpose.
  assign o_p0_pin = (i_p0_drive.out & i_p0_drive.oe) | (i_p0_ext & ~i_p0_drive.oe);
  assign o_p1_pin = (i_p1_drive.out & i_p1_drive.oe) | (i_p1_ext & ~i_p1_drive.oe);
  // Port 2 only sinks, so a released pad floats to the outside (pulled-up) level.
  assign o_p2_pin = (i_p2_drive.out & i_p2_drive.oe) | (i_p2_ext & ~i_p2_drive.oe);
endmodule

// File: verification/mfio_ports_test.sv
`timescale 1ns/1ps
module mfio_ports_test;
  // ------------------------------------------------------------
  // Bench signals.
  // ------------------------------------------------------------
  logic clk_sys, reset_n, rd, wr, dual, stop, fall;
  logic [11:0] addr;
  logic [7:0] wdata, rdata, ext0, ext1, seg0, seg1, periph, p0_pin, p1_pin, func0, reassign;
  logic [7:0] v, e, s;
  logic [2:0] ext2, p2_pin, func2;
  mfio_pkg::mfio_drv8_t drv0, drv1;
  mfio_pkg::mfio_drv3_t drv2;
  int fail_count, num_checks, cycles, falls;

  mfio_ports i_dut (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_cpu_addr(addr),
    .i_cpu_wdata(wdata), .i_cpu_read_sample_state(rd), .i_cpu_write_update_state(wr),
    .o_cpu_rdata(rdata), .i_p0_pin(p0_pin), .i_p1_pin(p1_pin), .i_p2_pin(p2_pin),
    .i_p0_lcd_seg(seg0), .i_p1_lcd_seg(seg1), .i_p0_periph_out(periph),
    .i_dual_clock_mode(dual), .i_stop_mode(stop), .o_p0_drive(drv0), .o_p1_drive(drv1),
    .o_p2_drive(drv2), .o_p0_func_in(func0), .o_p2_func_in(func2), .o_p2_bit0_fall(fall),
    .o_pin_reassign_select(reassign));
  mfio_pin_model i_pins (.i_p0_drive(drv0), .i_p1_drive(drv1), .i_p2_drive(drv2),
    .i_p0_ext(ext0), .i_p1_ext(ext1), .i_p2_ext(ext2), .o_p0_pin(p0_pin),
    .o_p1_pin(p1_pin), .o_p2_pin(p2_pin));

  // ------------------------------------------------------------
  // Clock, watchdog and edge counting.
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Counting on the falling edge keeps clear of the registered pulse changing.
  always @(negedge clk_sys) begin
    cycles++;
    if (fall === 1'b1) falls++;
    if (cycles == 5000) begin
      fail_count++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // Access tasks and comparison.
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Two edges let both the register and the registered drive land.
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // One write state pulse, then the drive is given time to follow.
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  // One read state pulse; the answer is read just after the edge that takes it.
  task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 12'h000;
    wdata = 8'h00;
    ext0 = 8'h5A;
    ext1 = 8'hC3;
    ext2 = 3'h7;
    seg0 = 8'h96;
    seg1 = 8'h69;
    periph = 8'hFF;
    dual = 1'b0;
    stop = 1'b0;
    fail_count = 0;
    num_checks = 0;
    cycles = 0;
    falls = 0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    settle();
    // Everything comes out of reset released; ports 0 and 1 cleared, port 2 latch all ones.
    chk("p0 oe", drv0.oe, 8'h00);
    chk("p1 oe", drv1.oe, 8'h00);
    chk("p2 oe", {5'h00, drv2.oe}, 8'h00);
    rd_reg(mfio_pkg::ADDR_P0_DIR, v);
    chk("p0 dir", v, 8'h00);
    rd_reg(mfio_pkg::ADDR_P0_LCD, v);
    chk("p0 lcd", v, 8'h00);
    rd_reg(mfio_pkg::ADDR_P1_DIR, v);
    chk("p1 dir", v, 8'h00);
    rd_reg(mfio_pkg::ADDR_P1_LCD, v);
    chk("p1 lcd", v, 8'h00);
    rd_reg(mfio_pkg::ADDR_P1_LATCH, v);
    chk("p1 data", v, 8'hC3);
    rd_reg(mfio_pkg::ADDR_P2_LATCH, v);
    chk("p2 latch", v, 8'h07);
    // Reassignment goes first, before any pin is configured.
    wr_reg(mfio_pkg::ADDR_REASSIGN, 8'h3C);
    chk("reassign", reassign, 8'h3C);
    // Mixed direction and LCD select, overlapping on bits 5 and 4.
    for (int p = 0; p < 2; p++) begin
      e = (p == 0) ? ext0 : ext1;
      s = (p == 0) ? seg0 : seg1;
      wr_reg(mfio_pkg::ADDR_P0_LATCH + 12'(p), 8'hA5);
      wr_reg(mfio_pkg::ADDR_P0_DIR + 12'(p), 8'hF0);
      wr_reg(mfio_pkg::ADDR_P0_LCD + 12'(p), 8'h3C);
      rd_reg(mfio_pkg::ADDR_P0_LATCH + 12'(p), v);
      chk("port data read", v, 8'hA0 | (e & 8'h03));
      v = (p == 0) ? p0_pin : p1_pin;
      chk("port pads", v, (s & 8'h3C) | 8'h80 | (e & 8'h03));
    end
    // The serial output level is gated by the latch on port 0.
    @(posedge clk_sys);
    periph <= 8'h0F;
    settle();
    chk("gated pads", p0_pin, (seg0 & 8'h3C) | (ext0 & 8'h03));
    @(posedge clk_sys);
    periph <= 8'hFF;
    // Input bits are taken in the read state only.
    wr_reg(mfio_pkg::ADDR_P0_LCD, 8'h00);
    wr_reg(mfio_pkg::ADDR_P0_DIR, 8'h00);
    @(posedge clk_sys);
    addr <= mfio_pkg::ADDR_P0_LATCH;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    ext0 <= 8'h81;
    #1 chk("sampled", rdata, 8'h5A);
    rd_reg(mfio_pkg::ADDR_P0_LATCH, v);
    chk("resampled", v, 8'h81);
    chk("p0 func in", func0, 8'h81);
    // Read-modify-write copies pin levels of input bits into the latch.
    wr_reg(mfio_pkg::ADDR_P0_LATCH, 8'h00);
    wr_reg(mfio_pkg::ADDR_P0_DIR, 8'h0F);
    rd_reg(mfio_pkg::ADDR_P0_LATCH, v);
    chk("rmw read", v, 8'h80);
    wr_reg(mfio_pkg::ADDR_P0_LATCH, v | 8'h01);
    wr_reg(mfio_pkg::ADDR_P0_DIR, 8'hFF);
    rd_reg(mfio_pkg::ADDR_P0_LATCH, v);
    chk("rmw latch", v, 8'h81);
    // Port 2: separate latch and pin views, oscillator and stop overrides.
    wr_reg(mfio_pkg::ADDR_P2_LATCH, 8'h02);
    chk("p2 oe", {5'h00, drv2.oe}, 8'h05);
    rd_reg(mfio_pkg::ADDR_P2_PIN, v);
    chk("p2 pins", v, 8'h02);
    rd_reg(mfio_pkg::ADDR_P2_LATCH, v);
    chk("p2 latch", v, 8'h02);
    chk("driven fall", 8'(falls), 8'h01);
    @(posedge clk_sys);
    dual <= 1'b1;
    settle();
    chk("dual clock oe", {5'h00, drv2.oe}, 8'h01);
    @(posedge clk_sys);
    stop <= 1'b1;
    settle();
    chk("stop oe", {5'h00, drv2.oe}, 8'h00);
    @(posedge clk_sys);
    dual <= 1'b0;
    stop <= 1'b0;
    settle();
    chk("single clock oe", {5'h00, drv2.oe}, 8'h05);
    chk("redriven fall", 8'(falls), 8'h02);
    // Latch back to ones before the bits serve as inputs.
    wr_reg(mfio_pkg::ADDR_P2_LATCH, 8'h07);
    @(posedge clk_sys);
    ext2 <= 3'h6;
    settle();
    chk("input fall", 8'(falls), 8'h03);
    chk("p2 func in", {5'h00, func2}, 8'h06);
    // Refused accesses change nothing and read as zero.
    wr_reg(mfio_pkg::ADDR_P2_PIN, 8'h00);
    rd_reg(mfio_pkg::ADDR_P2_LATCH, v);
    chk("pin write ignored", v, 8'h07);
    rd_reg(12'h123, v);
    chk("unmapped read", v, 8'h00);
    // A reset in mid-run must bring every register back to its reset value.
    // Bit 0 of port 2 is let back up on the same edge that reset goes in, so that no edge is owed.
    @(posedge clk_sys);
    ext2 <= 3'h7;
    reset_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    settle();
    chk("reset p0 oe", drv0.oe, 8'h00);
    chk("reset p1 oe", drv1.oe, 8'h00);
    chk("reset p2 oe", {5'h00, drv2.oe}, 8'h00);
    chk("no reset fall", 8'(falls), 8'h03);
    chk("reset reassign", reassign, 8'h00);
    rd_reg(mfio_pkg::ADDR_P0_DIR, v);
    chk("reset p0 dir", v, 8'h00);
    rd_reg(mfio_pkg::ADDR_P1_LCD, v);
    chk("reset p1 lcd", v, 8'h00);
    // With every bit an output, the data read shows the cleared latch.
    wr_reg(mfio_pkg::ADDR_P0_DIR, 8'hFF);
    rd_reg(mfio_pkg::ADDR_P0_LATCH, v);
    chk("reset p0 latch", v, 8'h00);
    wr_reg(mfio_pkg::ADDR_P1_DIR, 8'hFF);
    rd_reg(mfio_pkg::ADDR_P1_LATCH, v);
    chk("reset p1 latch", v, 8'h00);
    end_of_test();
  end
endmodule
